// >>> hw/sasp_defs.vh
// Constants of the second asynchronous serial port
// Assumes a classic Wishbone slave with 32-bit data, 8-bit registers in the low byte
// Function
// - Nine-bit mode frame is eleven bits
// - Buffer write starts send, loads ninth bit
// - Shifting starts at next divide-by-16 rollover
// - Start, nine bits, stop; done at stop
// - Receive only when enabled, on falling edge
// - Sample at 16x, counter reset on edge
// - Majority vote of states 7, 8, 9
// - Nonzero start bit returns to idle
// - Load data and ninth bit if done clear
// - Nine-bit mode needs stop bit one
// - Check enabled needs ninth bit one
// - Eight-bit mode check needs stop one
// - Receive done set at stop, software clears
// - Transmit done set by hardware, software clears
// - Framing error flag sticky until cleared
// - Format bit selects eight or nine bits
// - Buffer write transmits, read returns received
// - Reserved bits read zero, ignore writes
// - Eight-bit frame ten bits, stop to ninth
`ifndef SASP_DEFS_VH
`define SASP_DEFS_VH
`define SASP_ADR_CTRL 4'h0
`define SASP_ADR_FMT 4'h4
`define SASP_ADR_DATA 4'h8
`define SASP_CTRL_FE 7
`define SASP_CTRL_REN 4
`define SASP_CTRL_TB8 3
`define SASP_CTRL_RB8 2
`define SASP_CTRL_TI 1
`define SASP_CTRL_RI 0
`define SASP_FMT_SEL 1
`define SASP_FMT_CHK 0
`define SASP_CTRL_MASK 8'h9f
`define SASP_FMT_MASK 8'h03
`define SASP_RESET_BYTE 8'h00
`define SASP_SAMPLE_A 4'h7
`define SASP_SAMPLE_B 4'h8
`define SASP_SAMPLE_C 4'h9
`define SASP_LAST_STATE 4'hf
`endif

// >>> hw/sasp_uart.v
// Second asynchronous serial port: registers, transmitter, receiver
// Assumes a one-clock baud tick at 16x bit rate from an external timer
`timescale 1ns/1ps
`include "sasp_defs.vh"
module sasp_uart (
	input wire ref_clk,
	input wire reset_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire baud_tick,
	input wire rxd,
	output reg txd
);
	localparam ST_IDLE = 2'd0;
	localparam ST_WAIT = 2'd1;
	localparam ST_SHIFT = 2'd2;

	function vote3;
		input a;
		input b;
		input c;
		vote3 = (a & b) | (a & c) | (b & c);
	endfunction

	reg [7:0] ctrl_ff;
	reg [1:0] fmt_ff;
	reg [7:0] rbuf_ff;
	reg [1:0] rx_sync_ff;
	reg rx_prev_ff;
	// Transmitter
	reg [1:0] tx_st_ff;
	reg [3:0] tx_div_ff;
	reg [3:0] tx_bit_ff;
	reg [9:0] tx_sh_ff;
	// Receiver
	reg rx_busy_ff;
	reg [3:0] rx_div_ff;
	reg [3:0] rx_bit_ff;
	reg [2:0] rx_smp_ff;
	reg [8:0] rx_sh_ff;

	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr_lo = bus_req & wb_we_i & wb_sel_i[0];
	wire wr_ctrl = wr_lo & (wb_adr_i == `SASP_ADR_CTRL);
	wire wr_fmt = wr_lo & (wb_adr_i == `SASP_ADR_FMT);
	wire wr_data = wr_lo & (wb_adr_i == `SASP_ADR_DATA);
	wire nine = fmt_ff[`SASP_FMT_SEL];
	wire chk = fmt_ff[`SASP_FMT_CHK];
	wire rx_in = rx_sync_ff[1];

	// Frame length less one: stop bit index
	wire [3:0] tx_last = nine ? 4'ha : 4'h9;
	wire tx_at_stop = (tx_st_ff == ST_SHIFT) && baud_tick &&
		(tx_div_ff == `SASP_LAST_STATE) && (tx_bit_ff == tx_last - 4'h1);
	wire tx_done_bit = (tx_st_ff == ST_SHIFT) && baud_tick &&
		(tx_div_ff == `SASP_LAST_STATE) && (tx_bit_ff == tx_last);

	// Receive bit decision at state 9
	wire rx_decide = rx_busy_ff && baud_tick && (rx_div_ff == `SASP_SAMPLE_C);
	wire bit_val = vote3(rx_smp_ff[1], rx_smp_ff[0], rx_in);
	// Start is index 0, so the stop bit sits at the frame length less one
	wire [3:0] rx_stop_idx = nine ? 4'ha : 4'h9;
	// Eight-bit frames leave the data one place higher in the shifter
	wire [7:0] rx_byte = nine ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
	wire [7:0] nxt_fmt = wb_dat_i[7:0] & `SASP_FMT_MASK;
	wire rx_is_stop = rx_decide && (rx_bit_ff == rx_stop_idx);
	wire start_bad = rx_decide && (rx_bit_ff == 4'h0) && bit_val;
	wire ninth_rx = nine ? rx_sh_ff[8] : bit_val;
	wire pass_chk = ~chk | (nine ? rx_sh_ff[8] : bit_val);
	wire load_ok = rx_is_stop && ~ctrl_ff[`SASP_CTRL_RI] && pass_chk &&
		(nine ? bit_val : 1'b1);
	wire frame_err = rx_is_stop & ~bit_val;
	wire fall = rx_prev_ff & ~rx_in & ctrl_ff[`SASP_CTRL_REN];

	reg [7:0] nxt_ctrl;
	always @* begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl)
			nxt_ctrl = wb_dat_i[7:0] & `SASP_CTRL_MASK;
		// Set wins over a same-cycle software clear
		if (tx_at_stop)
			nxt_ctrl[`SASP_CTRL_TI] = 1'b1;
		if (load_ok) begin
			nxt_ctrl[`SASP_CTRL_RI] = 1'b1;
			nxt_ctrl[`SASP_CTRL_RB8] = ninth_rx;
		end
		if (frame_err)
			nxt_ctrl[`SASP_CTRL_FE] = 1'b1;
	end

	always @(posedge ref_clk) begin
		if (!reset_n) begin
			ctrl_ff <= `SASP_RESET_BYTE;
			fmt_ff <= 2'b00;
			rbuf_ff <= `SASP_RESET_BYTE;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			rx_sync_ff <= 2'b11;
			rx_prev_ff <= 1'b1;
		end else begin
			ctrl_ff <= nxt_ctrl;
			if (wr_fmt)
				fmt_ff <= nxt_fmt[1:0];
			if (load_ok)
				rbuf_ff <= rx_byte;
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h0000_0000;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
				`SASP_ADR_CTRL: wb_dat_o <= {24'h00_0000, ctrl_ff};
				`SASP_ADR_FMT: wb_dat_o <= {30'h0000_0000, fmt_ff};
				`SASP_ADR_DATA: wb_dat_o <= {24'h00_0000, rbuf_ff};
				default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
			rx_sync_ff <= {rx_sync_ff[0], rxd};
			rx_prev_ff <= rx_in;
		end
	end

	// Transmitter: free-running divider, shifting aligned to its rollover
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			tx_st_ff <= ST_IDLE;
			tx_div_ff <= 4'h0;
			tx_bit_ff <= 4'h0;
			tx_sh_ff <= 10'h3ff;
			txd <= 1'b1;
		end else begin
			if (baud_tick)
				tx_div_ff <= tx_div_ff + 4'h1;
			case (tx_st_ff)
			ST_IDLE: begin
				txd <= 1'b1;
				if (wr_data) begin
					// Ninth bit is the transmit ninth-bit control, stop follows
					tx_sh_ff <= nine ? {1'b1, ctrl_ff[`SASP_CTRL_TB8], wb_dat_i[7:0]}
						: {2'b11, wb_dat_i[7:0]};
					tx_st_ff <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (baud_tick && tx_div_ff == `SASP_LAST_STATE) begin
					txd <= 1'b0;
					tx_bit_ff <= 4'h0;
					tx_st_ff <= ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (baud_tick && tx_div_ff == `SASP_LAST_STATE) begin
					if (tx_done_bit) begin
						txd <= 1'b1;
						tx_st_ff <= ST_IDLE;
					end else begin
						txd <= tx_sh_ff[0];
						tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
						tx_bit_ff <= tx_bit_ff + 4'h1;
					end
				end
			end
			default: tx_st_ff <= ST_IDLE;
			endcase
		end
	end

	// Receiver: 16 states per bit, divider restarts on the falling edge
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			rx_busy_ff <= 1'b0;
			rx_div_ff <= 4'h0;
			rx_bit_ff <= 4'h0;
			rx_smp_ff <= 3'b111;
			rx_sh_ff <= 9'h000;
		end else if (!rx_busy_ff) begin
			if (fall) begin
				rx_busy_ff <= 1'b1;
				rx_div_ff <= 4'h0;
				rx_bit_ff <= 4'h0;
			end
		end else if (!ctrl_ff[`SASP_CTRL_REN]) begin
			rx_busy_ff <= 1'b0;
		end else if (baud_tick) begin
			rx_div_ff <= rx_div_ff + 4'h1;
			if (rx_div_ff == `SASP_SAMPLE_A || rx_div_ff == `SASP_SAMPLE_B)
				rx_smp_ff <= {rx_smp_ff[1:0], rx_in};
			if (rx_decide) begin
				if (start_bad || rx_is_stop) begin
					rx_busy_ff <= 1'b0;
				end else begin
					if (rx_bit_ff != 4'h0)
						rx_sh_ff <= {bit_val, rx_sh_ff[8:1]};
					rx_bit_ff <= rx_bit_ff + 4'h1;
				end
			end
		end
	end
endmodule // sasp_uart

// >>> verification/sasp_assertions.sv
// Port checker for the serial port
// Assumes binding onto sasp_uart
`timescale 1ns/1ps
module sasp_assertions (
	input wire ref_clk,
	input wire reset_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire [3:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire baud_tick,
	input wire txd
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("ack");
	a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat");
	a_ctrl_resv: assert property (wb_ack_o && wb_adr_i == 4'h0 |-> wb_dat_o[6:5] == 2'h0)
		else $error("ctrl");
	a_fmt_resv: assert property (wb_ack_o && wb_adr_i == 4'h4 |-> wb_dat_o[7:2] == 6'h0)
		else $error("fmt");
	a_unmap_zero: assert property (wb_ack_o && wb_adr_i == 4'hc |-> wb_dat_o == 32'h0)
		else $error("unmapped");
	a_txd_tick: assert property ($changed(txd) |-> $past(baud_tick)) else $error("txd");
endmodule // sasp_assertions
bind sasp_uart sasp_assertions sasp_assertions_inst (.ref_clk(ref_clk), .reset_n(reset_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.baud_tick(baud_tick), .txd(txd));

// >>> verification/sasp_remote.sv
// Remote serial node on rxd and txd
// Assumes baud_tick at 16x bit rate
`timescale 1ns/1ps
module sasp_remote (
	input wire ref_clk,
	input wire baud_tick,
	input wire txd,
	output reg rxd
);
	integer i;
	initial rxd = 1'b1;
	task tk(input integer n);
		repeat (n) do @(posedge ref_clk); while (!baud_tick);
	endtask
	// Start, data lsb first, ninth, stop
	task send(input [10:0] f);
		for (i = 0; i < 11; i = i + 1) begin
			rxd <= f[i];
			tk(16);
		end
	endtask
	task recv(output [10:0] f);
		@(negedge txd);
		tk(8);
		for (i = 0; i < 11; i = i + 1) begin
			f = {txd, f[10:1]};
			tk(16);
		end
	endtask
endmodule // sasp_remote

// >>> verification/tb.sv
// Bench for the serial port
// Assumes the remote model on the serial pins
`timescale 1ns/1ps
module tb;
	reg ref_clk = 0, reset_n = 0, cyc = 0, we = 0, baud_tick = 0;
	reg [3:0] adr = 4'h0;
	reg [31:0] dat = 32'h0;
	reg [6:0] tc = 7'h00;
	reg [10:0] f;
	wire [31:0] q;
	wire ack, rxd, txd;
	integer n_errors = 0, compares = 0;
	sasp_uart sasp_uart_inst (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
		.wb_dat_o(q), .wb_ack_o(ack), .baud_tick(baud_tick), .rxd(rxd), .txd(txd));
	sasp_remote sasp_remote_inst (.ref_clk(ref_clk), .baud_tick(baud_tick), .txd(txd), .rxd(rxd));
	initial forever #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		// One tick per 82 clocks keeps the link at or below 38400 baud
		tc <= (tc == 7'h51) ? 7'h00 : tc + 7'h01;
		baud_tick <= tc == 7'h51;
	end
	task ck(input [31:0] g, input [31:0] e);
		compares = compares + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("unexpected at %0t: %h vs %h", $time, g, e);
		end
	endtask
	task xf(input w, input [3:0] a, input [7:0] d);
		@(posedge ref_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		do @(posedge ref_clk); while (ack !== 1'b1);
		cyc <= 1'b0;
	endtask
	task rc(input [3:0] a, input [7:0] e);
		xf(1'b0, a, 8'h0);
		ck(q, {24'h0, e});
	endtask
	task end_of_test;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#1800000;
		n_errors = n_errors + 1;
		end_of_test;
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		rc(4'h0, 8'h00);
		rc(4'h8, 8'h00);
		xf(1, 4'h0, 8'h78);
		rc(4'h0, 8'h18);
		xf(1, 4'h4, 8'hff);
		rc(4'h4, 8'h03);
		rc(4'hc, 8'h00);
		xf(1, 4'h4, 8'h02);
		xf(1, 4'h8, 8'ha5);
		sasp_remote_inst.recv(f);
		ck(f, {2'b11, 8'ha5, 1'b0});
		rc(4'h0, 8'h1a);
		$display("tx test done");
		xf(1, 4'h0, 8'h10);
		sasp_remote_inst.send({2'b10, 8'h3c, 1'b0});
		rc(4'h8, 8'h3c);
		rc(4'h0, 8'h11);
		sasp_remote_inst.send({2'b11, 8'h55, 1'b0});
		rc(4'h8, 8'h3c);
		xf(1, 4'h4, 8'h03);
		xf(1, 4'h0, 8'h10);
		sasp_remote_inst.send({2'b10, 8'h66, 1'b0});
		rc(4'h0, 8'h10);
		sasp_remote_inst.send({2'b11, 8'h99, 1'b0});
		rc(4'h8, 8'h99);
		xf(1, 4'h4, 8'h02);
		xf(1, 4'h0, 8'h10);
		sasp_remote_inst.send({2'b01, 8'h77, 1'b0});
		rc(4'h0, 8'h90);
		$display("rx test done");
		end_of_test;
	end
endmodule // tb
